// file: rtl/cfi_select.sv
// Function
// - Each of the six terminal groups takes one function: plain, counter, catch, interrupt, frequency.
// - A group counter runs only while its group function is counter.
// - Groups one and three choose single-phase or two-phase counting.
// - Group one counter may use the group two terminal as clear.
// - Group three counter may use the group four terminal as clear.
// - Groups two, four, five, six count single-phase only; two-phase requests ignored.
// - Up/down mode: rising pulse counts up if direction high, else down.
// - Two-edge mode: both B edges count, up when A leads.
// - Four-edge mode: every A and B edge counts, up when A leads.
//
// Local design decisions: register access over Wishbone and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module cfi_select
  import cfi_pkg::*;
(
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [31:0] wb_dat_in,
  input wire logic [3:0] wb_sel_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  input wire logic [7:0] term_in,
  output logic [7:0] plain_data_out,
  output logic [NGRP-1:0] catch_pulse_out,
  output logic [NGRP-1:0] irq_pulse_out,
  output logic [NGRP-1:0] freq_level_out,
  output logic [NGRP-1:0] cnt_en_out
);
  // ==========================================================
  // Pin synchronisers: three stages, filter on stages two and three
  logic [7:0] s1;
  logic [7:0] s2;
  logic [7:0] s3;
  logic [7:0] filt;
  logic [7:0] filt_q;
  logic input_terminal_first;
  logic input_terminal_eighth;
  logic group1_clear_terminal;
  logic group3_clear_terminal;

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s1 <= 8'h00;
      s2 <= 8'h00;
      s3 <= 8'h00;
      filt <= 8'h00;
      filt_q <= 8'h00;
    end else begin
      s1 <= term_in;
      s2 <= s1;
      s3 <= s2;
      filt <= (s3 & ~(s2 ^ s3)) | (filt & (s2 ^ s3)); // Change only once stable
      filt_q <= filt;
    end
  end

  assign input_terminal_first = filt[0];
  assign input_terminal_eighth = filt[7];
  assign group1_clear_terminal = filt[2];
  assign group3_clear_terminal = filt[5];

  // ==========================================================
  // Configuration registers
  logic [17:0] func_reg;
  logic [5:0] mode_reg;
  logic [17:0] next_func;
  logic [31:0] wmask;
  logic [31:0] func_wr;
  logic wr_stb;
  logic [NGRP-1:0] load;
  logic [CNT_W-1:0] cnt [NGRP];
  logic [CNT_W-1:0] load_val [NGRP];
  logic clr_on0;
  logic clr_on2;

  assign wmask = {{8{wb_sel_in[3]}}, {8{wb_sel_in[2]}}, {8{wb_sel_in[1]}}, {8{wb_sel_in[0]}}};
  assign wr_stb = wb_cyc_in && wb_stb_in && wb_we_in && !wb_ack_out;
  assign func_wr = ({14'h0, func_reg} & ~wmask) | (wb_dat_in & wmask);

  // Unknown function codes leave the field as it was
  always_comb begin
    next_func = func_reg;
    for (int g = 0; g < NGRP; g++) begin
      if (func_wr[3*g +: 3] <= FN_FREQ) begin
        next_func[3*g +: 3] = func_wr[3*g +: 3];
      end
    end
  end

  // Function and mode storage
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      func_reg <= FUNC_RST;
      mode_reg <= MODE_RST;
    end else if (wr_stb && wb_adr_in == ADDR_FUNC) begin
      func_reg <= next_func;
    end else if (wr_stb && wb_adr_in == ADDR_MODE && wb_sel_in[0]) begin
      mode_reg <= wb_dat_in[5:0];
    end
  end

  // Clear terminal borrowed only while the owning group counts
  assign clr_on0 = func_reg[2:0] == FN_COUNT && mode_reg[MODE_CLR];
  assign clr_on2 = func_reg[8:6] == FN_COUNT && mode_reg[MODE_G3 + MODE_CLR];

  // ==========================================================
  // Per-group counters and function outputs
  for (genvar g = 0; g < NGRP; g++) begin : grp
    localparam int P = GRP_PIN[g];
    localparam bit DUAL = (g == 0) || (g == 2);
    localparam int MB = (g == 2) ? MODE_G3 : 0;
    localparam int PB = DUAL ? P + 1 : P; // Keeps the unused B index inside the pin range
    logic is_cnt;
    logic a;
    logic b;
    logic tp;
    logic sel;
    logic clr;
    logic [31:0] cnt_addr;

    assign cnt_addr = 32'(ADDR_CNT0) + 32'(4 * g);
    // Borrowed clear pin stops its own group counting
    assign is_cnt = func_reg[3*g +: 3] == FN_COUNT
                    && !(g == 1 && clr_on0) && !(g == 3 && clr_on2);
    assign a = filt[P];
    assign b = DUAL ? filt[PB] : 1'b0;
    assign tp = DUAL ? mode_reg[MB + MODE_TP] : 1'b0;
    assign sel = DUAL ? mode_reg[MB + MODE_SEL] : 1'b0;
    assign clr = (g == 0) ? (clr_on0 && group1_clear_terminal)
                 : (g == 2) ? (clr_on2 && group3_clear_terminal) : 1'b0;
    assign load[g] = wr_stb && {24'h0, wb_adr_in} == cnt_addr;
    assign load_val[g] = (cnt[g] & ~wmask) | (wb_dat_in & wmask);

    cfi_count_core #(
      .W(CNT_W)
    ) u_core (
      .clk_in(clk_in),
      .arst_n_in(arst_n_in),
      .en_in(is_cnt),
      .two_phase_in(tp),
      .mode_in(sel),
      .a_in(a),
      .b_in(b),
      .clr_in(clr),
      .load_in(load[g]),
      .load_val_in(load_val[g]),
      .count_out(cnt[g])
    );

    // Catch and interrupt fire on the primary pin's rising edge
    always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
        catch_pulse_out[g] <= 1'b0;
        irq_pulse_out[g] <= 1'b0;
        freq_level_out[g] <= 1'b0;
        cnt_en_out[g] <= 1'b0;
      end else begin
        catch_pulse_out[g] <= func_reg[3*g +: 3] == FN_CATCH && a && !filt_q[P];
        irq_pulse_out[g] <= func_reg[3*g +: 3] == FN_IRQ && a && !filt_q[P];
        freq_level_out[g] <= func_reg[3*g +: 3] == FN_FREQ && a;
        cnt_en_out[g] <= is_cnt;
      end
    end
  end

  // Plain data shows a pin only while its group is plain and not borrowed
  for (genvar t = 0; t < 8; t++) begin : pin
    localparam int G = PIN_GRP[t];
    always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
        plain_data_out[t] <= 1'b0;
      end else begin
        plain_data_out[t] <= filt[t] && func_reg[3*G +: 3] == FN_PLAIN
                             && !(t == 2 && clr_on0) && !(t == 5 && clr_on2);
      end
    end
  end

  // ==========================================================
  // Wishbone classic slave: one wait state, unmapped reads give zero
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0;
    end else begin
      wb_ack_out <= wb_cyc_in && wb_stb_in && !wb_ack_out;
      if (wb_cyc_in && wb_stb_in && !wb_ack_out) begin
        if (wb_adr_in == ADDR_FUNC) begin
          wb_dat_out <= {14'h0, func_reg};
        end else if (wb_adr_in == ADDR_MODE) begin
          wb_dat_out <= {26'h0, mode_reg};
        end else if (wb_adr_in == ADDR_STAT) begin
          wb_dat_out <= {16'h0, 2'h0, cnt_en_out, filt};
        end else if (wb_adr_in >= ADDR_CNT0 && wb_adr_in <= ADDR_CNT5
                     && wb_adr_in[1:0] == 2'h0) begin
          wb_dat_out <= cnt[3'((wb_adr_in - ADDR_CNT0) >> 2)];
        end else begin
          wb_dat_out <= 32'h0;
        end
      end
    end
  end

  // ==========================================================
  // Checks
  sequence mode_wr_s;
    wr_stb && wb_adr_in == ADDR_MODE && wb_sel_in[0];
  endsequence
  sequence dual_up_s;
    ##1 (mode_reg[MODE_TP] && mode_reg[MODE_G3 + MODE_TP]);
  endsequence

  catch_fire_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    func_reg[2:0] == FN_CATCH && input_terminal_first && !filt_q[0]
    |=> catch_pulse_out[0])
    else $error("catch pulse missing on first terminal");
  irq_fire_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    func_reg[17:15] == FN_IRQ && input_terminal_eighth && !filt_q[7]
    |=> irq_pulse_out[5])
    else $error("interrupt pulse missing on eighth terminal");
  cnt_gate_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    func_reg[5:3] != FN_COUNT |=> !cnt_en_out[1])
    else $error("counter enabled for non-counter group");
  phase_sel_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    mode_wr_s ##0 (wb_dat_in[MODE_TP] && wb_dat_in[MODE_G3 + MODE_TP]) |-> dual_up_s)
    else $error("two-phase selection not stored");
  clear_g1_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    clr_on0 && group1_clear_terminal |=> cnt[0] == '0 ##1 !cnt_en_out[1])
    else $error("group one external clear failed");
  clear_g3_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    clr_on2 && group3_clear_terminal |=> cnt[2] == '0)
    else $error("group three external clear failed");
  single_only_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    grp[1].tp == 1'b0 && grp[3].tp == 1'b0 && grp[4].tp == 1'b0 && grp[5].tp == 1'b0)
    else $error("two-phase reached a single-phase group");
  plain_rst_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    func_reg == FUNC_RST |=> cnt_en_out == '0 && catch_pulse_out == '0
    && irq_pulse_out == '0 && freq_level_out == '0)
    else $error("special function active while all groups plain");
endmodule : cfi_select
`default_nettype wire

// file: rtl/cfi_pkg.sv
package cfi_pkg;
  // ==========================================================
  // Group functions
  localparam logic [2:0] FN_PLAIN = 3'h0;
  localparam logic [2:0] FN_COUNT = 3'h1;
  localparam logic [2:0] FN_CATCH = 3'h2;
  localparam logic [2:0] FN_IRQ = 3'h3;
  localparam logic [2:0] FN_FREQ = 3'h4;
  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] ADDR_FUNC = 8'h00;
  localparam logic [7:0] ADDR_MODE = 8'h04;
  localparam logic [7:0] ADDR_STAT = 8'h08;
  localparam logic [7:0] ADDR_CNT0 = 8'h10;
  localparam logic [7:0] ADDR_CNT5 = 8'h24;
  // ==========================================================
  // Reset values and fields
  localparam logic [17:0] FUNC_RST = 18'h0;
  localparam logic [5:0] MODE_RST = 6'h0;
  localparam int MODE_TP = 0;
  localparam int MODE_SEL = 1;
  localparam int MODE_CLR = 2;
  localparam int MODE_G3 = 3;
  localparam int CNT_W = 32;
  localparam int NGRP = 6;
  // Primary pin of each group, and owning group of each pin
  localparam int GRP_PIN [NGRP] = '{0, 2, 3, 5, 6, 7};
  localparam int PIN_GRP [8] = '{0, 0, 1, 2, 2, 3, 4, 5};
endpackage : cfi_pkg

// file: rtl/cfi_count_core.sv
`timescale 1ns/10ps
`default_nettype none
module cfi_count_core
  import cfi_pkg::*;
#(
  parameter int W = CNT_W
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic en_in,
  input wire logic two_phase_in,
  input wire logic mode_in,
  input wire logic a_in,
  input wire logic b_in,
  input wire logic clr_in,
  input wire logic load_in,
  input wire logic [W-1:0] load_val_in,
  output logic [W-1:0] count_out
);
  // ==========================================================
  // Edge detection
  logic a_q;
  logic b_q;
  logic ea;
  logic eb;
  logic step_up;
  logic step_dn;

  // Previous phase levels
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      a_q <= 1'b0;
      b_q <= 1'b0;
    end else begin
      a_q <= a_in;
      b_q <= b_in;
    end
  end

  assign ea = a_in ^ a_q;
  assign eb = b_in ^ b_q;

  // Step decode; both phases moving at once is not a valid quadrature step
  always_comb begin
    step_up = 1'b0;
    step_dn = 1'b0;
    if (en_in) begin
      if (!two_phase_in) begin
        if (ea && a_in) begin
          step_up = !mode_in || b_in;
          step_dn = mode_in && !b_in;
        end
      end else if (!mode_in) begin
        if (eb && !ea) begin
          step_up = (a_in == b_in);
          step_dn = (a_in != b_in);
        end
      end else if (ea ^ eb) begin
        step_up = ea ? (a_in != b_in) : (a_in == b_in);
        step_dn = !step_up;
      end
    end
  end

  // ==========================================================
  // Counter: clear beats load beats counting, wraps at the ends
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      count_out <= '0;
    end else if (clr_in) begin
      count_out <= '0;
    end else if (load_in) begin
      count_out <= load_val_in;
    end else if (step_up) begin
      count_out <= count_out + W'(1);
    end else if (step_dn) begin
      count_out <= count_out - W'(1);
    end
  end

  // ==========================================================
  // Checks
  gate_hold_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    !en_in && !clr_in && !load_in |=> $stable(count_out))
    else $error("counter moved while disabled");
  updown_up_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    en_in && !two_phase_in && mode_in && a_in && !a_q && b_in && !clr_in && !load_in
    |=> count_out == $past(count_out) + W'(1))
    else $error("up/down count did not rise");
  updown_dn_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    en_in && !two_phase_in && mode_in && a_in && !a_q && !b_in && !clr_in && !load_in
    |=> count_out == $past(count_out) - W'(1))
    else $error("up/down count did not fall");
  quad_two_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    en_in && two_phase_in && !mode_in && eb && !ea && (a_in == b_in) && !clr_in
    && !load_in |=> count_out == $past(count_out) + W'(1))
    else $error("two-edge count missed a step");
  quad_four_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    en_in && two_phase_in && mode_in && ea && !eb && (a_in == b_in) && !clr_in
    && !load_in |=> count_out == $past(count_out) - W'(1))
    else $error("four-edge count missed a step");
endmodule : cfi_count_core
`default_nettype wire

// file: testbench/cfi_pulse_src.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Pulse source standing in for encoders on the eight terminals
module cfi_pulse_src (
  input wire logic clk_in,
  output var logic [7:0] term_out
);
  initial term_out = 8'h00;
  // Seven cycles per level keeps every edge well past the filter spacing
  task automatic drive_pin(input int pin, input logic v);
    @(posedge clk_in);
    term_out[pin] <= v;
    repeat (6) @(posedge clk_in);
  endtask : drive_pin
  // Whole pulses only, so the pin always returns low
  task automatic pulse(input int pin, input int n);
    repeat (n) begin
      drive_pin(pin, 1'b1);
      drive_pin(pin, 1'b0);
    end
  endtask : pulse
  // One full quadrature period; forward lets phase A lead
  task automatic quad(input int a, input int b, input logic fwd);
    drive_pin(fwd ? a : b, 1'b1);
    drive_pin(fwd ? b : a, 1'b1);
    drive_pin(fwd ? a : b, 1'b0);
    drive_pin(fwd ? b : a, 1'b0);
  endtask : quad
endmodule : cfi_pulse_src
`default_nettype wire

// file: testbench/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import cfi_pkg::*;
  // ==========================================================
  // Signals
  logic clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic wb_cyc_in = 1'b0;
  logic wb_stb_in = 1'b0;
  logic wb_we_in = 1'b0;
  logic [7:0] wb_adr_in = 8'h00;
  logic [31:0] wb_dat_in = 32'h0;
  logic [3:0] wb_sel_in = 4'h0;
  logic [31:0] wb_dat_out;
  logic wb_ack_out;
  wire logic [7:0] term;
  logic [7:0] plain_data_out;
  logic [NGRP-1:0] freq_level_out;
  logic [NGRP-1:0] cnt_en_out;
  logic [NGRP-1:0] catch_pulse_out;
  logic [NGRP-1:0] irq_pulse_out;
  int fail_count = 0;
  int n_tests = 0;
  int catch_seen = 0;
  int irq_seen = 0;
  // Pulses are tallied at every rising clock edge so a one-cycle output cannot slip past
  always @(posedge clk_in) begin
    catch_seen <= catch_seen + $countones(catch_pulse_out);
    irq_seen <= irq_seen + $countones(irq_pulse_out);
  end
  always #5 clk_in = ~clk_in;
  // ==========================================================
  // Design and pulse source
  cfi_select i_cfi_select (
    .clk_in(clk_in), .arst_n_in(arst_n_in), .wb_cyc_in(wb_cyc_in),
    .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
    .wb_dat_in(wb_dat_in), .wb_sel_in(wb_sel_in), .wb_dat_out(wb_dat_out),
    .wb_ack_out(wb_ack_out), .term_in(term), .plain_data_out(plain_data_out),
    .catch_pulse_out(catch_pulse_out), .irq_pulse_out(irq_pulse_out),
    .freq_level_out(freq_level_out),
    .cnt_en_out(cnt_en_out)
  );
  cfi_pulse_src src (.clk_in(clk_in), .term_out(term));
  // ==========================================================
  // Bus and compare helpers
  // Waits for ack without assuming a latency; a stuck bus counts as a mismatch
  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                         input logic [3:0] sel, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk_in);
    wb_cyc_in <= 1'b1;
    wb_stb_in <= 1'b1;
    wb_we_in <= we;
    wb_adr_in <= adr;
    wb_dat_in <= dat;
    wb_sel_in <= sel;
    do begin
      @(posedge clk_in);
      n++;
    end while (wb_ack_out !== 1'b1 && n < 20);
    if (n >= 20) chk({31'h0, wb_ack_out}, 32'h1); // Missing ack counts as a mismatch
    rd = wb_dat_out;
    wb_cyc_in <= 1'b0;
    wb_stb_in <= 1'b0;
  endtask : wb_xfer
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
    logic [31:0] d;
    wb_xfer(1'b0, adr, 32'h0, 4'hf, d);
    chk(d, exp);
  endtask : rd_chk
  // Counters are zeroed so each scenario judges only its own pulses
  task automatic setup(input logic [17:0] fn, input logic [5:0] md);
    logic [31:0] d;
    wb_xfer(1'b1, ADDR_FUNC, {14'h0, fn}, 4'hf, d);
    wb_xfer(1'b1, ADDR_MODE, {26'h0, md}, 4'hf, d);
    for (int g = 0; g < NGRP; g++) wb_xfer(1'b1, 8'(ADDR_CNT0 + 4 * g), 32'h0, 4'hf, d);
  endtask : setup
  // ==========================================================
  // Scenarios
  task automatic test_reset();
    rd_chk(ADDR_FUNC, 32'h0);
    rd_chk(ADDR_MODE, 32'h0);
    rd_chk(ADDR_STAT, 32'h0);
    rd_chk(8'hfc, 32'h0);
    rd_chk(8'h20, 32'h0);
    chk({26'h0, cnt_en_out}, 32'h0);
  endtask : test_reset
  // All pins high, every function code applied to all groups in turn
  task automatic test_funcs();
    logic [2:0] c;
    for (int p = 0; p < 8; p++) src.drive_pin(p, 1'b1);
    for (int k = 0; k < 5; k++) begin
      c = 3'(k);
      setup({6{c}}, 6'h00);
      repeat (3) @(posedge clk_in);
      chk({26'h0, cnt_en_out}, (c == FN_COUNT) ? 32'h3f : 32'h0);
      chk({24'h0, plain_data_out}, (c == FN_PLAIN) ? 32'hff : 32'h0);
      chk({26'h0, freq_level_out}, (c == FN_FREQ) ? 32'h3f : 32'h0);
      rd_chk(ADDR_FUNC, {14'h0, {6{c}}});
    end
    for (int p = 0; p < 8; p++) src.drive_pin(p, 1'b0);
  endtask : test_funcs
  task automatic test_updown();
    setup(18'h00001, 6'h02);
    src.drive_pin(1, 1'b1);
    src.pulse(0, 3);
    rd_chk(ADDR_CNT0, 32'h3);
    src.drive_pin(1, 1'b0);
    src.pulse(0, 1);
    rd_chk(ADDR_CNT0, 32'h2);
  endtask : test_updown
  task automatic test_quad();
    setup(18'h00001, 6'h01);
    src.quad(0, 1, 1'b1);
    rd_chk(ADDR_CNT0, 32'h2);
    src.quad(0, 1, 1'b0);
    src.quad(0, 1, 1'b0);
    rd_chk(ADDR_CNT0, 32'hffff_fffe);
    setup(18'h00041, 6'h1b);
    src.quad(0, 1, 1'b1);
    src.quad(3, 4, 1'b0);
    rd_chk(ADDR_CNT0, 32'h4);
    rd_chk(8'h18, 32'hffff_fffc);
  endtask : test_quad
  task automatic test_clear();
    setup(18'h00041, 6'h24);
    src.pulse(0, 2);
    src.pulse(3, 2);
    src.drive_pin(2, 1'b1);
    rd_chk(ADDR_CNT0, 32'h0);
    rd_chk(8'h18, 32'h2);
    src.drive_pin(5, 1'b1);
    rd_chk(8'h18, 32'h0);
    chk({24'h0, plain_data_out}, 32'h0);
    src.drive_pin(2, 1'b0);
    src.drive_pin(5, 1'b0);
  endtask : test_clear
  // Two-phase requests for the single-phase groups have nowhere to land
  task automatic test_single_only();
    logic [31:0] d;
    setup(18'h09000, 6'h00);
    wb_xfer(1'b1, ADDR_MODE, 32'hffff_ffff, 4'hf, d);
    rd_chk(ADDR_MODE, 32'h3f);
    src.pulse(6, 2);
    src.pulse(7, 1);
    rd_chk(8'h20, 32'h2);
    rd_chk(ADDR_CNT5, 32'h1);
  endtask : test_single_only
  // Catch and interrupt fire on primary pins only; unknown codes and masked bytes are refused
  task automatic test_pulses();
    logic [31:0] d;
    int c0;
    int i0;
    c0 = catch_seen;
    i0 = irq_seen;
    setup(18'h12492, 6'h00);
    src.pulse(0, 2);
    src.pulse(1, 1);
    chk(32'(catch_seen - c0), 32'h2);
    wb_xfer(1'b1, ADDR_FUNC, 32'h0003_ffff, 4'hf, d);
    rd_chk(ADDR_FUNC, 32'h0001_2492);
    wb_xfer(1'b1, ADDR_MODE, 32'hffff_ffff, 4'he, d);
    rd_chk(ADDR_MODE, 32'h0);
    setup(18'h1b6db, 6'h00);
    src.pulse(7, 1);
    src.pulse(4, 1);
    chk(32'(irq_seen - i0), 32'h1);
    chk(32'(catch_seen - c0), 32'h2);
  endtask : test_pulses
  // ==========================================================
  // Verdict, watchdog and main sequence
  task automatic give_verdict();
    if (fail_count == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : give_verdict
  // Whole run needs about a thousand cycles; the 20000-cycle limit allows ample margin
  initial begin
    #200000;
    chk(32'h0, 32'h1); // Expiry counts as a mismatch
    give_verdict();
  end
  initial begin
    repeat (3) @(posedge clk_in);
    arst_n_in <= 1'b1;
    test_reset();
    test_funcs();
    test_updown();
    test_quad();
    test_clear();
    test_single_only();
    test_pulses();
    // A reset in mid-run must bring back the all-plain state
    arst_n_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    arst_n_in <= 1'b1;
    test_reset();
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
